// *** press_intervention_start_logic.sv ***
// start sequencing for a press started by light-curtain interventions
// assumes all inputs synchronous to clk_sys_in and settings held static
//
// Behaviour
// - one high-low-high on the curtain input counts as one intervention
// - enable and curtain high raise request; next intervention enables
// - unauthorized output high while curtain low, unless muted or at top
// - enable drops on disable, intrusion, timeout or power-up may need full
// - restart interlock none restarts without a full start sequence
// - interlock three lets restart without full sequence during ramp-up
// - after a regular top stop only the interventions are needed
// - count selectable 1 to 8; start only when exactly reached
// - too many interventions drop enable and raise unauthorized at once
// - interval monitor 0 off or 1 to 500 s bounds both sequences
// - interval expiry output rises once the monitor time is reached
// - muting time 0 off or 1 to 7200 s; ramp input mutes only then
// - full sequence: interventions then restart pulse in order one
// - order two: restart pulse first, then the interventions
// - second enable: 1 absent, 2 every start, 3 full start only
// - first intervention valid after top reached or after ramp-up start
// - restart interlock: 1 none, 2 always, 3 downstroke or initial stop
// - minimum intervention and restart pulse widths 100 or 350 ms
// - interventions shorter than the minimum are ignored
// - restart pulse low-high-low, high at least minimum, at most 30 s
// - top-only start position flags a stop away from top
// - optional fault output on expiry or an unexpected intervention
// - restart request high while an active interlock awaits a pulse
// - top rising after a cycle clears count, drops enable, requests
`timescale 1ns/1ps
module press_intervention_start_logic #(
  parameter int unsigned TICK_CYCLES = press_pkg::TICK_CYCLES,
  parameter int unsigned MAX_COUNT = press_pkg::MAX_INTERVENTIONS
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic main_enable_in,
  input wire logic second_enable_in,
  input wire logic curtain_in,
  input wire logic upper_dead_point_in,
  input wire logic ramp_up_in,
  input wire logic restart_in,
  input wire logic [3:0] intervention_count_setting_in,
  input wire logic order_reverse_in,
  input wire logic [12:0] ramp_mute_time_s_in,
  input wire logic [8:0] interval_time_s_in,
  input wire logic [1:0] second_enable_use_in,
  input wire logic [1:0] first_intervention_origin_in,
  input wire logic [1:0] restart_lock_in,
  input wire logic restart_min_long_in,
  input wire logic pulse_min_long_in,
  input wire logic start_pos_top_only_in,
  input wire logic fault_use_in,
  output logic press_enable_out,
  output logic restart_request_out,
  output logic intervention_request_out,
  output logic interval_expiry_out,
  output logic unauthorized_out,
  output logic wrong_position_out,
  output logic fault_out
);
  import press_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 32768 ||
      MAX_COUNT < 1 || MAX_COUNT > 14)
  begin : g_bad_param
    $error("unsupported tick or count parameter");
  end

  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
  localparam logic [3:0] MAX_CNT = 4'(MAX_COUNT);

  function automatic logic [8:0] min_ms(input logic long_sel);
    min_ms = long_sel ? PULSE_LONG_MS : PULSE_SHORT_MS;
  endfunction

  // base timing
  logic [14:0] tick_cnt_q, tick_cnt_d;
  logic [9:0] ms_cnt_q, ms_cnt_d;
  logic ms_tick_q, ms_tick_d, sec_tick_q, sec_tick_d;

  always_comb
  begin
    tick_cnt_d = tick_cnt_q + 15'h1;
    ms_tick_d = 1'h0;
    if (tick_cnt_q == TICK_LAST)
    begin
      tick_cnt_d = 15'h0;
      ms_tick_d = 1'h1;
    end
    ms_cnt_d = ms_cnt_q;
    sec_tick_d = 1'h0;
    if (ms_tick_q)
    begin
      if (ms_cnt_q == MS_PER_S_LAST)
      begin
        ms_cnt_d = 10'h0;
        sec_tick_d = 1'h1;
      end
      else
        ms_cnt_d = ms_cnt_q + 10'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tick_cnt_q <= 15'h0;
      ms_cnt_q <= 10'h0;
      ms_tick_q <= 1'h0;
      sec_tick_q <= 1'h0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      ms_tick_q <= ms_tick_d;
      sec_tick_q <= sec_tick_d;
    end
  end

  // input history and pulse measurement
  logic curtain_q, top_q, ramp_q, restart_q;
  logic [8:0] low_ms_q, low_ms_d;
  logic [14:0] high_ms_q, high_ms_d;
  logic [12:0] mute_s_q, mute_s_d;
  logic low_armed_q, low_armed_d, armed_q, armed_d;
  logic curtain_fall, curtain_rise, top_rise, ramp_rise, restart_fall;
  logic intervention_ok, restart_ok, mute_on, arm_event;

  assign curtain_fall = curtain_q & ~curtain_in;
  assign curtain_rise = ~curtain_q & curtain_in;
  assign top_rise = ~top_q & upper_dead_point_in;
  assign ramp_rise = ~ramp_q & ramp_up_in;
  assign restart_fall = restart_q & ~restart_in;
  // origin two arms on ramp-up so an early intervention can count
  assign arm_event = (first_intervention_origin_in == SET_TWO) ?
                     ramp_rise : top_rise;
  assign intervention_ok = curtain_rise & low_armed_q &
    (low_ms_q >= min_ms(pulse_min_long_in));
  assign restart_ok = restart_fall &
    (high_ms_q >= {6'h0, min_ms(restart_min_long_in)}) &
    (high_ms_q <= RESTART_MAX_MS);
  // muting only when a time is set; the ramp input is ignored otherwise
  assign mute_on = (ramp_mute_time_s_in != 13'h0) & ramp_up_in &
    ~upper_dead_point_in & (mute_s_q < ramp_mute_time_s_in);

  always_comb
  begin
    low_ms_d = low_ms_q;
    if (curtain_fall)
      low_ms_d = 9'h0;
    else if (!curtain_in && ms_tick_q && low_ms_q < PULSE_LONG_MS)
      low_ms_d = low_ms_q + 9'h1;
    high_ms_d = high_ms_q;
    if (restart_in && !restart_q)
      high_ms_d = 15'h0;
    else if (restart_in && ms_tick_q && high_ms_q <= RESTART_MAX_MS)
      high_ms_d = high_ms_q + 15'h1;
    mute_s_d = mute_s_q;
    if (ramp_rise)
      mute_s_d = 13'h0;
    else if (sec_tick_q && mute_s_q != MUTE_S_MAX)
      mute_s_d = mute_s_q + 13'h1;
    armed_d = armed_q;
    if (arm_event)
      armed_d = 1'h1;
    else if (press_enable_out)
      armed_d = 1'h0;
    low_armed_d = low_armed_q;
    // enabled and at top: an extra intervention must reach the excess check
    if (curtain_fall)
      low_armed_d = armed_q | arm_event |
        (enable_q & upper_dead_point_in);
    else if (curtain_rise)
      low_armed_d = 1'h0;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      curtain_q <= 1'h1;
      top_q <= 1'h1;
      ramp_q <= 1'h0;
      restart_q <= 1'h0;
      low_ms_q <= 9'h0;
      high_ms_q <= 15'h0;
      mute_s_q <= 13'h0;
      armed_q <= RST_ARMED;
      low_armed_q <= 1'h0;
    end
    else
    begin
      curtain_q <= curtain_in;
      top_q <= upper_dead_point_in;
      ramp_q <= ramp_up_in;
      restart_q <= restart_in;
      low_ms_q <= low_ms_d;
      high_ms_q <= high_ms_d;
      mute_s_q <= mute_s_d;
      armed_q <= armed_d;
      low_armed_q <= low_armed_d;
    end
  end

  // sequencing
  logic enable_q, enable_d, need_full_q, need_full_d;
  logic done_q, done_d, excess_q, excess_d, timeout_q, timeout_d;
  logic run_q, run_d, wrong_q, wrong_d, unauth_q, unauth_d;
  logic req_q, req_d, rreq_q, rreq_d, fault_q, fault_d;
  logic [3:0] count_q, count_d;
  logic [8:0] run_s_q, run_s_d;
  logic need_restart, count_hit, set_ok, lock_on_drop, en2_need;
  logic unauth_now, drop, start_ok;

  assign need_restart = need_full_q & (restart_lock_in != SET_ONE);
  assign count_hit = count_q == intervention_count_setting_in;
  assign set_ok = intervention_count_setting_in != 4'h0 &&
                  intervention_count_setting_in <= MAX_CNT;
  assign unauth_now = ~curtain_in & ~mute_on & ~upper_dead_point_in;
  assign en2_need = second_enable_use_in == SET_TWO ||
    (second_enable_use_in == SET_THREE && need_full_q);
  // an extra intervention while enabled stops the press at the next clock
  assign drop = ~main_enable_in | unauth_now | excess_q | timeout_q |
    (intervention_ok & enable_q);
  assign start_ok = ~enable_q & count_hit & set_ok & main_enable_in &
    (~need_restart | done_q) & (~en2_need | second_enable_in) &
    ~timeout_q & ~wrong_q & ~excess_q & ~unauth_now;

  always_comb
  begin
    unique case (restart_lock_in)
      SET_TWO: lock_on_drop = 1'h1;
      SET_THREE: lock_on_drop = ~ramp_up_in;
      default: lock_on_drop = 1'h0;
    endcase
  end

  always_comb
  begin
    enable_d = enable_q;
    need_full_d = need_full_q;
    done_d = done_q;
    excess_d = excess_q;
    timeout_d = timeout_q;
    run_d = run_q;
    run_s_d = run_s_q;
    wrong_d = wrong_q;
    count_d = count_q;
    if (run_q && sec_tick_q && run_s_q != RUN_S_MAX)
      run_s_d = run_s_q + 9'h1;
    // clears come first so a same-cycle excess still sets
    if (top_rise)
    begin
      wrong_d = 1'h0;
      excess_d = 1'h0;
    end
    if (restart_ok && (timeout_q || excess_q))
    begin
      timeout_d = 1'h0;
      excess_d = 1'h0;
    end
    if (restart_ok && need_restart && (order_reverse_in || count_hit))
    begin
      done_d = 1'h1;
      if (order_reverse_in && !run_q)
      begin
        run_d = 1'h1;
        run_s_d = 9'h0;
      end
    end
    if (intervention_ok && !enable_q &&
        !(order_reverse_in && need_restart && !done_q))
    begin
      if (count_q >= intervention_count_setting_in)
      begin
        excess_d = 1'h1;
        count_d = 4'h0;
        need_full_d = 1'h1;
      end
      else
      begin
        count_d = count_q + 4'h1;
        timeout_d = 1'h0;
        if (!run_q)
        begin
          run_d = 1'h1;
          run_s_d = 9'h0;
        end
      end
    end
    if (start_ok)
    begin
      enable_d = 1'h1;
      need_full_d = 1'h0;
      done_d = 1'h0;
      run_d = 1'h0;
    end
    else if (enable_q && drop)
    begin
      enable_d = 1'h0;
      count_d = 4'h0;
      if (lock_on_drop)
        need_full_d = 1'h1;
      if (start_pos_top_only_in && !upper_dead_point_in)
        wrong_d = 1'h1;
    end
    else if (enable_q && top_rise)
    begin
      enable_d = 1'h0;
      count_d = 4'h0;
      run_d = 1'h1;
      run_s_d = 9'h0;
    end
    if (intervention_ok && enable_q)
      excess_d = 1'h1;
    // expiry sets last so it wins over any clear this cycle
    if (run_q && interval_time_s_in != 9'h0 &&
        run_s_q >= interval_time_s_in)
    begin
      timeout_d = 1'h1;
      enable_d = 1'h0;
      need_full_d = 1'h1;
      count_d = 4'h0;
      done_d = 1'h0;
      run_d = 1'h0;
    end
    unauth_d = unauth_now | excess_d;
    req_d = ~enable_d & main_enable_in & curtain_in &
      (count_d < intervention_count_setting_in) &
      (~order_reverse_in | ~need_restart | done_q);
    rreq_d = ~enable_d & need_full_d & (restart_lock_in != SET_ONE) &
      ~done_d & (order_reverse_in | count_hit);
    fault_d = fault_use_in & (timeout_d | excess_d);
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      enable_q <= 1'h0;
      need_full_q <= RST_NEED_FULL;
      done_q <= 1'h0;
      excess_q <= 1'h0;
      timeout_q <= 1'h0;
      run_q <= 1'h0;
      run_s_q <= 9'h0;
      wrong_q <= 1'h0;
      count_q <= 4'h0;
      unauth_q <= 1'h0;
      req_q <= 1'h0;
      rreq_q <= 1'h0;
      fault_q <= 1'h0;
    end
    else
    begin
      enable_q <= enable_d;
      need_full_q <= need_full_d;
      done_q <= done_d;
      excess_q <= excess_d;
      timeout_q <= timeout_d;
      run_q <= run_d;
      run_s_q <= run_s_d;
      wrong_q <= wrong_d;
      count_q <= count_d;
      unauth_q <= unauth_d;
      req_q <= req_d;
      rreq_q <= rreq_d;
      fault_q <= fault_d;
    end
  end

  assign press_enable_out = enable_q;
  assign restart_request_out = rreq_q;
  assign intervention_request_out = req_q;
  assign interval_expiry_out = timeout_q;
  assign unauthorized_out = unauth_q;
  assign wrong_position_out = wrong_q;
  assign fault_out = fault_q;

  default clocking assert_clk @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  unauth_hold_a: assert property (unauth_now |=> unauthorized_out)
    else $error("unauthorized output missing while curtain low");
  excess_stop_a: assert property (
    intervention_ok && enable_q |=> !press_enable_out && unauthorized_out)
    else $error("excess intervention did not stop press");
  exact_count_a: assert property (
    $rose(press_enable_out) |-> $past(count_hit) && $past(set_ok))
    else $error("press enabled with wrong intervention count");
  top_clear_a: assert property (
    enable_q && top_rise |=> !press_enable_out && count_q == 4'h0)
    else $error("top rise did not end the cycle");
  restart_gate_a: assert property (
    $rose(press_enable_out) |-> !$past(need_restart) || $past(done_q))
    else $error("full start without restart pulse");
  expiry_set_a: assert property (
    run_q && interval_time_s_in != 9'h0 && run_s_q >= interval_time_s_in
    |=> interval_expiry_out && !press_enable_out)
    else $error("interval expiry not signalled");
  second_en_a: assert property (
    $rose(press_enable_out) && second_enable_use_in == SET_TWO
    |-> $past(second_enable_in))
    else $error("start without second enable");
  wrong_pos_a: assert property (
    enable_q && drop && start_pos_top_only_in && !upper_dead_point_in
    |=> wrong_position_out)
    else $error("stop away from top not flagged");
  short_pulse_a: assert property (
    curtain_rise && low_ms_q < min_ms(pulse_min_long_in)
    |=> count_q <= $past(count_q))
    else $error("short intervention counted");
  lock_none_a: assert property (
    enable_q && drop && restart_lock_in == SET_ONE && !need_full_q
    && !intervention_ok |=> !need_full_q)
    else $error("restart interlock set although none configured");
endmodule

// *** press_pkg.sv ***
// constants shared by the press start sequencing logic
// assumes a single 20 MHz system clock and synchronous inputs
package press_pkg;
  // clock and base tick
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned TICK_CYCLES =
    TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [9:0] MS_PER_S_LAST = 10'h3E7;
  // pulse limits in milliseconds
  localparam logic [8:0] PULSE_SHORT_MS = 9'h064;
  localparam logic [8:0] PULSE_LONG_MS = 9'h15E;
  localparam int unsigned RESTART_MAX_S = 30;
  localparam logic [14:0] RESTART_MAX_MS = 15'(RESTART_MAX_S * 1000);
  // counter saturation values and the intervention count limit
  localparam logic [8:0] RUN_S_MAX = 9'h1FF;
  localparam logic [12:0] MUTE_S_MAX = 13'h1FFF;
  localparam int unsigned MAX_INTERVENTIONS = 8;
  // three-way setting codes
  localparam logic [1:0] SET_ONE = 2'h1;
  localparam logic [1:0] SET_TWO = 2'h2;
  localparam logic [1:0] SET_THREE = 2'h3;
  // reset values
  localparam logic RST_NEED_FULL = 1'h1;
  localparam logic RST_ARMED = 1'h1;
endpackage

// *** press_model.sv ***
// press mechanics model: top contact driven by the stroke under enable
// assumes the enable comes from the start logic on the same clock
`timescale 1ns/1ps
module press_model #(
  parameter int unsigned STROKE = 300,
  parameter int unsigned SLOW_DELAY = 3000
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic press_enable_in,
  input wire logic slow_in,
  output logic top_out,
  output logic ramp_out
);
  logic top_q;
  logic [15:0] cnt_q;
  logic [15:0] delay;
  // slow start keeps the ram at top long enough for an extra intervention
  assign delay = slow_in ? 16'(SLOW_DELAY) : 16'h000A;
  // a dropped enable freezes the ram where it is, like a real brake
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      top_q <= 1'h1;
      cnt_q <= 16'h0000;
    end
    else if (!press_enable_in)
    begin
      if (top_q)
        cnt_q <= 16'h0000;
    end
    else if (cnt_q == (top_q ? delay : 16'(STROKE)))
    begin
      top_q <= ~top_q;
      cnt_q <= 16'h0000;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
  assign top_out = top_q;
  assign ramp_out = ~top_q;
endmodule

// *** tb.sv ***
// self-checking bench for the press intervention start logic
// assumes a shortened ms tick of 4 clocks and the press model alongside
`timescale 1ns/1ps
module tb;
  import press_pkg::*;
  localparam int TICK = 4;
  logic clk_sys_in = 1'h0;
  logic nrst_in = 1'h0;
  logic main_enable_in = 1'h1;
  logic curtain_in = 1'h1;
  logic restart_in = 1'h0;
  logic [3:0] count_set = 4'h1;
  logic order_rev = 1'h0;
  logic [8:0] interval_s = 9'h000;
  logic [1:0] lock_set = SET_ONE;
  logic long_min = 1'h0;
  logic slow = 1'h0;
  logic second_en = 1'h1;
  logic [1:0] en2_use = SET_ONE;
  logic top_only = 1'h0;
  logic [12:0] mute_set = 13'h0000;
  logic wrong_position_out;
  logic top;
  logic ramp;
  logic press_enable_out;
  logic restart_request_out;
  logic intervention_request_out;
  logic interval_expiry_out;
  logic unauthorized_out;
  logic fault_out;
  int num_errors = 0;
  int total_checks = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  press_intervention_start_logic #(
    .TICK_CYCLES(TICK)
  ) u_press_intervention_start_logic (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .main_enable_in(main_enable_in),
    .second_enable_in(second_en),
    .curtain_in(curtain_in),
    .upper_dead_point_in(top),
    .ramp_up_in(ramp),
    .restart_in(restart_in),
    .intervention_count_setting_in(count_set),
    .order_reverse_in(order_rev),
    .ramp_mute_time_s_in(mute_set),
    .interval_time_s_in(interval_s),
    .second_enable_use_in(en2_use),
    .first_intervention_origin_in(SET_ONE),
    .restart_lock_in(lock_set),
    .restart_min_long_in(long_min),
    .pulse_min_long_in(long_min),
    .start_pos_top_only_in(top_only),
    .fault_use_in(1'h1),
    .press_enable_out(press_enable_out),
    .restart_request_out(restart_request_out),
    .intervention_request_out(intervention_request_out),
    .interval_expiry_out(interval_expiry_out),
    .unauthorized_out(unauthorized_out),
    .wrong_position_out(wrong_position_out),
    .fault_out(fault_out)
  );

  press_model u_press_model (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .press_enable_in(press_enable_out),
    .slow_in(slow),
    .top_out(top),
    .ramp_out(ramp)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      num_errors++;
    end
  endtask

  // settings are static, so each configuration gets its own reset
  task automatic setup(input logic [3:0] cnt, input logic [1:0] lock,
                       input logic rev, input logic [8:0] ivl,
                       input logic lng, input logic slw,
                       input logic tpo = 1'h0,
                       input logic [1:0] en2 = SET_ONE,
                       input logic [12:0] mte = 13'h0000);
    @(posedge clk_sys_in);
    nrst_in <= 1'h0;
    top_only <= tpo;
    en2_use <= en2;
    mute_set <= mte;
    count_set <= cnt;
    lock_set <= lock;
    order_rev <= rev;
    interval_s <= ivl;
    long_min <= lng;
    slow <= slw;
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  // curtain low pulse, or restart high pulse, of the given ms length
  task automatic pulse(input logic on_restart, input int ms);
    @(posedge clk_sys_in);
    if (on_restart)
      restart_in <= 1'h1;
    else
      curtain_in <= 1'h0;
    repeat (ms * TICK) @(posedge clk_sys_in);
    restart_in <= 1'h0;
    curtain_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  // sel 0 waits on the top contact, sel 1 on interval expiry
  task automatic wait_until(input int sel, input logic lvl, input int bound);
    int n;
    n = 0;
    while (((sel == 0) ? top : interval_expiry_out) !== lvl)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (n > bound)
      begin
        $display("CHECK FAILED wait %0d expected %b seen timeout", sel, lvl);
        num_errors++;
        test_done();
      end
    end
  endtask

  initial
  begin
    // minimal start, top stop and cycle start, unauthorized entry
    setup(4'h1, SET_ONE, 1'h0, 9'h000, 1'h0, 1'h0);
    check("request", 1'h1, intervention_request_out);
    pulse(1'h0, 60);
    check("enable short", 1'h0, press_enable_out);
    pulse(1'h0, 120);
    check("enable", 1'h1, press_enable_out);
    check("request on", 1'h0, intervention_request_out);
    wait_until(0, 1'h0, 100);
    wait_until(0, 1'h1, 1000);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check("enable top", 1'h0, press_enable_out);
    check("request top", 1'h1, intervention_request_out);
    pulse(1'h0, 120);
    check("enable cycle", 1'h1, press_enable_out);
    wait_until(0, 1'h0, 100);
    @(posedge clk_sys_in);
    curtain_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check("unauth", 1'h1, unauthorized_out);
    check("enable unauth", 1'h0, press_enable_out);
    @(posedge clk_sys_in);
    curtain_in <= 1'h1;
    // two interventions with the long minimum, then one too many
    setup(4'h2, SET_ONE, 1'h0, 9'h000, 1'h1, 1'h1);
    pulse(1'h0, 200);
    pulse(1'h0, 400);
    check("enable one of two", 1'h0, press_enable_out);
    pulse(1'h0, 400);
    check("enable two", 1'h1, press_enable_out);
    pulse(1'h0, 400);
    check("enable excess", 1'h0, press_enable_out);
    check("unauth excess", 1'h1, unauthorized_out);
    check("fault excess", 1'h1, fault_out);
    // interval monitor of one second runs out after one of two
    setup(4'h2, SET_ONE, 1'h0, 9'h001, 1'h0, 1'h0);
    pulse(1'h0, 120);
    check("expiry early", 1'h0, interval_expiry_out);
    wait_until(1, 1'h1, 1000 * TICK + 200);
    check("expiry", 1'h1, interval_expiry_out);
    check("fault expiry", 1'h1, fault_out);
    check("enable expiry", 1'h0, press_enable_out);
    // interlock always, standard order
    setup(4'h1, SET_TWO, 1'h0, 9'h000, 1'h0, 1'h0);
    pulse(1'h0, 120);
    check("enable no restart", 1'h0, press_enable_out);
    check("restart req", 1'h1, restart_request_out);
    pulse(1'h1, 120);
    check("enable full", 1'h1, press_enable_out);
    check("restart req off", 1'h0, restart_request_out);
    // interlock always, reverse order, then main enable drop
    setup(4'h1, SET_TWO, 1'h1, 9'h000, 1'h0, 1'h1);
    pulse(1'h0, 120);
    check("enable rev early", 1'h0, press_enable_out);
    pulse(1'h1, 120);
    pulse(1'h0, 120);
    check("enable rev", 1'h1, press_enable_out);
    @(posedge clk_sys_in);
    main_enable_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check("enable main off", 1'h0, press_enable_out);
    @(posedge clk_sys_in);
    main_enable_in <= 1'h1;
    pulse(1'h0, 120);
    check("enable needs full", 1'h0, press_enable_out);
    // second enable per start, ramp muting, stop away from top
    setup(4'h1, SET_ONE, 1'h0, 9'h000, 1'h0, 1'h0, 1'h1, SET_TWO,
          13'h0002);
    @(posedge clk_sys_in);
    second_en <= 1'h0;
    pulse(1'h0, 120);
    check("enable no second", 1'h0, press_enable_out);
    @(posedge clk_sys_in);
    second_en <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check("enable second", 1'h1, press_enable_out);
    wait_until(0, 1'h0, 100);
    @(posedge clk_sys_in);
    curtain_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check("unauth muted", 1'h0, unauthorized_out);
    check("enable muted", 1'h1, press_enable_out);
    @(posedge clk_sys_in);
    curtain_in <= 1'h1;
    @(posedge clk_sys_in);
    main_enable_in <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check("wrong position", 1'h1, wrong_position_out);
    check("enable stop", 1'h0, press_enable_out);
    @(posedge clk_sys_in);
    main_enable_in <= 1'h1;
    test_done();
  end
endmodule
